// *** design/dpbs_device.sv ***
// Burst SRAM device end: separate read and write ports over one address bus
// How it works
// - Read starts on low read select
// - Read returns two words, low first
// - PLL on 1.5 cycles, off one
// - Outputs float after next output edge
// - Write select low captures first word
// - Complement edge latches address, writes row
// - Pending write finishes after deselect
// - Lane enables gate each beat's bytes
// - Both output clocks high: single clock
// - Echo strobes follow output clocks, or input clocks in single clock mode
// - Read and write run independently
// - Reads see the most recent write
// - Selects sampled on true edge only
// - Deselect spares the other port
// - Impedance retune every 1024 clocks
// - PLL locks after 20 us
// - Controller may stop clocks to reset PLL
// - Words at cycles t+1 and t+1.5, or t+1.5 and t+2 with PLL
// - Powers up deselected, outputs floating
// - No enabled lanes, nothing written
`timescale 1ns/1ps
`default_nettype none
module dpbs_device
  import dpbs_pkg::*;
#(
  parameter int MEM_AW = DPBS_ADDR_W,
  parameter int LOCK_CYC = DPBS_LOCK_CYC,
  parameter int STOP_CYC = DPBS_STOP_CYC
) (
  input wire logic clk_sys,          // System clock
  input wire logic reset_n,          // Asynchronous reset
  dpbs_if.dev bus,                   // Pins from the controller
  output logic pll_locked,           // PLL lock status
  output logic impedance_tune,       // Pulse on each impedance retune
  output logic single_clock_mode     // Strap result
);
  localparam int SW = 7 + DPBS_LANES + DPBS_ADDR_W + DPBS_DATA_W;
  localparam int ZW = $clog2(DPBS_ZQ_PERIOD);
  localparam int LW = $clog2(LOCK_CYC + 1);
  localparam int GW = $clog2(STOP_CYC + 1);
  localparam int TW = $clog2(DPBS_STRAP_CYC + 1);

  function automatic logic [DPBS_DATA_W-1:0] lane_merge(
    input logic [DPBS_DATA_W-1:0] old_w,
    input logic [DPBS_DATA_W-1:0] new_w,
    input logic [DPBS_LANES-1:0] en
  );
    logic [DPBS_DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < DPBS_LANES; i++) begin
      if (en[i]) begin
        res[i*DPBS_LANE_W +: DPBS_LANE_W] = new_w[i*DPBS_LANE_W +: DPBS_LANE_W];
      end
    end
    return res;
  endfunction : lane_merge

  logic [DPBS_ROW_W-1:0] mem [2**MEM_AW];

  logic [SW-1:0] sync1_reg, sync2_reg;
  logic k_s, kb_s, c_s, cb_s, rps_n_s, wps_n_s, bypass_n_s;
  logic [DPBS_LANES-1:0] bwe_n_s;
  logic [DPBS_ADDR_W-1:0] addr_s;
  logic [DPBS_DATA_W-1:0] d_s;
  logic k_prev_reg, kb_prev_reg, oc_prev_reg, ocb_prev_reg;
  logic [TW-1:0] strap_cnt_reg;
  logic strap_done_reg;
  logic oc, ocb, krise, kbrise, oc_rise, ocb_rise, legacy;
  logic first_edge, second_edge;

  logic rd_pend_reg;
  logic [MEM_AW-1:0] rd_addr_reg;
  logic arm_reg;
  logic arm_now, consume;
  logic [DPBS_ROW_W-1:0] row_buf_reg, row_now;
  logic [DPBS_DATA_W-1:0] hi_reg;
  dpbs_rd_state_t rd_state_reg;

  logic wr_pend_reg;
  logic [DPBS_DATA_W-1:0] wlo_reg;
  logic [DPBS_LANES-1:0] wbe_lo_reg;
  logic [MEM_AW-1:0] waddr;
  logic wr_commit;

  logic [ZW-1:0] zq_cnt_reg;
  logic [LW-1:0] lock_cnt_reg;
  logic [GW-1:0] gap_cnt_reg;

  assign {k_s, kb_s, c_s, cb_s, rps_n_s, wps_n_s, bwe_n_s, addr_s, d_s, bypass_n_s} = sync2_reg;

  // Every pin passes two flops before use
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {bus.input_strobe_true, bus.input_strobe_comp, bus.output_timing_true,
                    bus.output_timing_comp, bus.read_port_select_n, bus.write_port_select_n,
                    bus.byte_lane_enable_n, bus.addr, bus.wdata, bus.pll_bypass_n};
      sync2_reg <= sync1_reg;
    end
  end

  // Strap is taken a few cycles after release, once the synchronisers hold pin levels
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      strap_cnt_reg <= '0;
      strap_done_reg <= 1'b0;
      single_clock_mode <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 1'b1;
      if (strap_cnt_reg == TW'(DPBS_STRAP_CYC)) begin
        strap_done_reg <= 1'b1;
        single_clock_mode <= c_s & cb_s;
      end
    end
  end

  assign oc = single_clock_mode ? k_s : c_s;
  assign ocb = single_clock_mode ? kb_s : cb_s;
  assign krise = strap_done_reg & k_s & ~k_prev_reg;
  assign kbrise = strap_done_reg & kb_s & ~kb_prev_reg;
  assign oc_rise = strap_done_reg & oc & ~oc_prev_reg;
  assign ocb_rise = strap_done_reg & ocb & ~ocb_prev_reg;
  assign legacy = ~bypass_n_s;
  assign first_edge = legacy ? oc_rise : ocb_rise;
  assign second_edge = legacy ? ocb_rise : oc_rise;

  // Edge history and echo strobes, one cycle behind the data they time
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      k_prev_reg <= 1'b0;
      kb_prev_reg <= 1'b0;
      oc_prev_reg <= 1'b0;
      ocb_prev_reg <= 1'b0;
      bus.echo_timing_strobe <= 1'b0;
      bus.echo_timing_strobe_n <= 1'b0;
    end else begin
      k_prev_reg <= k_s;
      kb_prev_reg <= kb_s;
      oc_prev_reg <= oc;
      ocb_prev_reg <= ocb;
      bus.echo_timing_strobe <= oc_prev_reg;
      bus.echo_timing_strobe_n <= ocb_prev_reg;
    end
  end

  // Read port: address on the true edge, row fetched at the following true edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= '0;
      row_buf_reg <= '0;
    end else if (krise) begin
      rd_pend_reg <= ~rps_n_s;
      if (!rps_n_s) begin
        rd_addr_reg <= addr_s[MEM_AW-1:0];
      end
      if (rd_pend_reg) begin
        row_buf_reg <= mem[rd_addr_reg];
      end
    end
  end

  // A fetch made on this very edge is used straight from the array
  assign row_now = arm_reg ? row_buf_reg : mem[rd_addr_reg];
  assign arm_now = arm_reg | (krise & rd_pend_reg);
  assign consume = first_edge & arm_now & (rd_state_reg != DPBS_RD_HI);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      arm_reg <= 1'b0;
    end else begin
      arm_reg <= arm_now & ~consume;
    end
  end

  // Output beats: low word, high word, then float unless another read follows
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_state_reg <= DPBS_RD_IDLE;
      bus.rdata <= '0;
      bus.rdata_oe <= 1'b0;
      hi_reg <= '0;
    end else begin
      unique case (rd_state_reg)
        DPBS_RD_IDLE, DPBS_RD_TAIL: begin
          if (consume) begin
            bus.rdata <= row_now[DPBS_DATA_W-1:0];
            hi_reg <= row_now[DPBS_ROW_W-1:DPBS_DATA_W];
            bus.rdata_oe <= 1'b1;
            rd_state_reg <= DPBS_RD_HI;
          end else if (first_edge && rd_state_reg == DPBS_RD_TAIL) begin
            bus.rdata_oe <= 1'b0;
            rd_state_reg <= DPBS_RD_IDLE;
          end
        end
        DPBS_RD_HI: begin
          if (second_edge) begin
            bus.rdata <= hi_reg;
            rd_state_reg <= DPBS_RD_TAIL;
          end
        end
        default: begin
          rd_state_reg <= DPBS_RD_IDLE;
          bus.rdata_oe <= 1'b0;
        end
      endcase
    end
  end

  // Write port: first beat on the true edge, address and second beat on the complement
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_reg <= 1'b0;
      wlo_reg <= '0;
      wbe_lo_reg <= '0;
    end else if (krise) begin
      wr_pend_reg <= ~wps_n_s;
      if (!wps_n_s) begin
        wlo_reg <= d_s;
        wbe_lo_reg <= ~bwe_n_s;
      end
    end else if (kbrise) begin
      wr_pend_reg <= 1'b0;
    end
  end

  assign waddr = addr_s[MEM_AW-1:0];
  assign wr_commit = kbrise & wr_pend_reg;

  always_ff @(posedge clk_sys) begin
    if (wr_commit) begin
      mem[waddr] <= {lane_merge(mem[waddr][DPBS_ROW_W-1:DPBS_DATA_W], d_s, ~bwe_n_s),
                     lane_merge(mem[waddr][DPBS_DATA_W-1:0], wlo_reg, wbe_lo_reg)};
    end
  end

  // Impedance retune tick
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      zq_cnt_reg <= '0;
      impedance_tune <= 1'b0;
    end else begin
      impedance_tune <= krise && (zq_cnt_reg == ZW'(DPBS_ZQ_PERIOD - 1));
      if (krise) begin
        zq_cnt_reg <= zq_cnt_reg + 1'b1;
      end
    end
  end

  // PLL lock: needs a stable input clock, a stopped clock restarts the count
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gap_cnt_reg <= '0;
      lock_cnt_reg <= '0;
      pll_locked <= 1'b0;
    end else begin
      if (krise | kbrise) begin
        gap_cnt_reg <= '0;
      end else if (gap_cnt_reg != GW'(STOP_CYC)) begin
        gap_cnt_reg <= gap_cnt_reg + 1'b1;
      end
      if (gap_cnt_reg == GW'(STOP_CYC) || !bypass_n_s) begin
        lock_cnt_reg <= '0;
      end else if (lock_cnt_reg != LW'(LOCK_CYC)) begin
        lock_cnt_reg <= lock_cnt_reg + 1'b1;
      end
      pll_locked <= bypass_n_s && (lock_cnt_reg == LW'(LOCK_CYC));
    end
  end
endmodule : dpbs_device
`default_nettype wire

// *** design/dpbs_pkg.sv ***
// Shared constants and types for the burst SRAM device and its controller
package dpbs_pkg;
  localparam int DPBS_DATA_W = 18;
  localparam int DPBS_ADDR_W = 21;
  localparam int DPBS_LANES = 2;
  localparam int DPBS_LANE_W = 9;
  localparam int DPBS_ROW_W = 2 * DPBS_DATA_W;
  localparam int DPBS_CLK_NS = 25;
  localparam int DPBS_PLL_LOCK_US = 20;
  localparam int DPBS_LOCK_CYC = (DPBS_PLL_LOCK_US * 1000 + DPBS_CLK_NS - 1) / DPBS_CLK_NS;
  localparam int DPBS_ZQ_PERIOD = 1024;
  localparam int DPBS_STOP_CYC = 16;
  localparam int DPBS_K_HALF = 4;
  // Strap waits until the first output clock fall has crossed the synchroniser
  localparam int DPBS_STRAP_CYC = DPBS_K_HALF + 2;
  typedef enum logic [1:0] {
    DPBS_RD_IDLE = 2'h0,
    DPBS_RD_HI = 2'h1,
    DPBS_RD_TAIL = 2'h3
  } dpbs_rd_state_t;
endpackage : dpbs_pkg

// *** design/dpbs_if.sv ***
// Pin bundle between the burst SRAM device and its controller
`timescale 1ns/1ps
`default_nettype none
interface dpbs_if;
  import dpbs_pkg::*;
  logic input_strobe_true;
  logic input_strobe_comp;
  logic output_timing_true;
  logic output_timing_comp;
  logic read_port_select_n;
  logic write_port_select_n;
  logic [DPBS_LANES-1:0] byte_lane_enable_n;
  logic [DPBS_ADDR_W-1:0] addr;
  logic [DPBS_DATA_W-1:0] wdata;
  logic pll_bypass_n;
  logic [DPBS_DATA_W-1:0] rdata;
  logic rdata_oe;
  logic echo_timing_strobe;
  logic echo_timing_strobe_n;
  modport dev (
    input input_strobe_true, input_strobe_comp, output_timing_true, output_timing_comp,
    input read_port_select_n, write_port_select_n, byte_lane_enable_n, addr, wdata,
    input pll_bypass_n,
    output rdata, rdata_oe, echo_timing_strobe, echo_timing_strobe_n
  );
  modport ctl (
    output input_strobe_true, input_strobe_comp, output_timing_true, output_timing_comp,
    output read_port_select_n, write_port_select_n, byte_lane_enable_n, addr, wdata,
    output pll_bypass_n,
    input rdata, rdata_oe, echo_timing_strobe, echo_timing_strobe_n
  );
endinterface : dpbs_if
`default_nettype wire

// *** design/dpbs_ctrl.sv ***
// Memory controller end: makes the link clocks and runs read and write bursts
`timescale 1ns/1ps
`default_nettype none
module dpbs_ctrl
  import dpbs_pkg::*;
#(
  parameter int K_HALF = DPBS_K_HALF,
  parameter int LOCK_CYC = DPBS_LOCK_CYC
) (
  input wire logic clk_sys,                     // System clock
  input wire logic reset_n,                     // Asynchronous reset
  dpbs_if.ctl bus,                              // Pins to the device
  input wire logic use_pll,                     // Strap: run device with PLL
  input wire logic single_clock,                // Strap: single clock mode
  input wire logic rd_req,                      // Read request
  input wire logic [DPBS_ADDR_W-1:0] rd_addr,   // Read row address
  output logic rd_ready,                        // Read request accepted now
  output logic [DPBS_ROW_W-1:0] rd_data,        // Read row, low word first beat
  output logic rd_valid,                        // Read row valid pulse
  input wire logic wr_req,                      // Write request
  input wire logic [DPBS_ADDR_W-1:0] wr_addr,   // Write row address
  input wire logic [DPBS_ROW_W-1:0] wr_data,    // Write row
  input wire logic [2*DPBS_LANES-1:0] wr_be,    // Byte lane enables, both beats
  output logic wr_ready                         // Write request accepted now
);
  localparam int PW = $clog2(2 * K_HALF);
  localparam int LW = $clog2(LOCK_CYC + 1);
  localparam logic [PW-1:0] PH_LAST = PW'(2 * K_HALF - 1);
  localparam logic [PW-1:0] PH_KFALL = PW'(K_HALF - 1);
  localparam logic [PW-1:0] PH_FIRST = PW'(K_HALF + K_HALF / 2 - 1);
  localparam logic [PW-1:0] PH_SECOND = PW'(K_HALF / 2 - 1);

  logic [PW-1:0] phase_reg;
  logic [LW-1:0] init_cnt_reg;
  logic init_done_reg;
  logic strap_done_reg;
  logic single_reg;
  logic rd_hold_reg, wr_hold_reg, wr_go_reg;
  logic [DPBS_ADDR_W-1:0] ra_reg, wa_reg, wa_go_reg;
  logic [DPBS_ROW_W-1:0] wd_reg;
  logic [DPBS_DATA_W-1:0] whi_go_reg;
  logic [2*DPBS_LANES-1:0] wbe_reg;
  logic [DPBS_LANES-1:0] wbe_hi_go_reg;
  logic rd_acc, wr_acc, first_slot, second_slot;
  logic [DPBS_DATA_W+2:0] rsync1_reg, rsync2_reg;
  logic cq_prev_reg, cqn_prev_reg, beat_idx_reg;
  logic [DPBS_DATA_W-1:0] lo_reg;
  logic cq_s, cqn_s, oe_s;
  logic [DPBS_DATA_W-1:0] q_s;

  assign rd_acc = rd_req & rd_ready;
  assign wr_acc = wr_req & wr_ready;
  assign first_slot = init_done_reg && (phase_reg == PH_FIRST);
  assign second_slot = phase_reg == PH_SECOND;
  assign {cq_s, cqn_s, oe_s, q_s} = rsync2_reg;

  // Straps are caught once after reset release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      strap_done_reg <= 1'b0;
      single_reg <= 1'b0;
      bus.pll_bypass_n <= 1'b1;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      single_reg <= single_clock;
      bus.pll_bypass_n <= use_pll;
    end
  end

  // Clock divider: input and output clock pairs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= '0;
      bus.input_strobe_true <= 1'b1;
      bus.input_strobe_comp <= 1'b0;
      bus.output_timing_true <= 1'b1;
      bus.output_timing_comp <= 1'b1;
    end else begin
      phase_reg <= (phase_reg == PH_LAST) ? '0 : phase_reg + 1'b1;
      if (phase_reg == PH_LAST || phase_reg == PH_KFALL) begin
        bus.input_strobe_true <= phase_reg == PH_LAST;
        bus.input_strobe_comp <= phase_reg != PH_LAST;
        bus.output_timing_true <= single_reg | (phase_reg == PH_LAST);
        bus.output_timing_comp <= single_reg | (phase_reg != PH_LAST);
      end
    end
  end

  // Hold off traffic until the device PLL has locked
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      init_cnt_reg <= '0;
      init_done_reg <= 1'b0;
    end else if (strap_done_reg && !init_done_reg) begin
      init_cnt_reg <= init_cnt_reg + 1'b1;
      init_done_reg <= !bus.pll_bypass_n || (init_cnt_reg == LW'(LOCK_CYC));
    end
  end

  // Request holding and acceptance
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_hold_reg <= 1'b0;
      wr_hold_reg <= 1'b0;
      rd_ready <= 1'b0;
      wr_ready <= 1'b0;
      ra_reg <= '0;
      wa_reg <= '0;
      wd_reg <= '0;
      wbe_reg <= '0;
    end else begin
      if (rd_acc) begin
        ra_reg <= rd_addr;
      end
      if (wr_acc) begin
        wa_reg <= wr_addr;
        wd_reg <= wr_data;
        wbe_reg <= wr_be;
      end
      rd_hold_reg <= rd_acc | (rd_hold_reg & ~first_slot);
      wr_hold_reg <= wr_acc | (wr_hold_reg & ~first_slot);
      rd_ready <= init_done_reg & ~(rd_acc | (rd_hold_reg & ~first_slot));
      wr_ready <= init_done_reg & ~(wr_acc | (wr_hold_reg & ~first_slot));
    end
  end

  // Pin drive, changed mid half-period so the device samples settled values
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus.read_port_select_n <= 1'b1;
      bus.write_port_select_n <= 1'b1;
      bus.byte_lane_enable_n <= '1;
      bus.addr <= '0;
      bus.wdata <= '0;
      wr_go_reg <= 1'b0;
      wa_go_reg <= '0;
      whi_go_reg <= '0;
      wbe_hi_go_reg <= '0;
    end else if (first_slot) begin
      bus.read_port_select_n <= ~rd_hold_reg;
      bus.write_port_select_n <= ~wr_hold_reg;
      bus.addr <= ra_reg;
      bus.wdata <= wd_reg[DPBS_DATA_W-1:0];
      bus.byte_lane_enable_n <= wr_hold_reg ? ~wbe_reg[DPBS_LANES-1:0] : '1;
      wr_go_reg <= wr_hold_reg;
      wa_go_reg <= wa_reg;
      whi_go_reg <= wd_reg[DPBS_ROW_W-1:DPBS_DATA_W];
      wbe_hi_go_reg <= wbe_reg[2*DPBS_LANES-1:DPBS_LANES];
    end else if (second_slot) begin
      bus.read_port_select_n <= 1'b1;
      bus.write_port_select_n <= 1'b1;
      bus.addr <= wr_go_reg ? wa_go_reg : bus.addr;
      bus.wdata <= whi_go_reg;
      bus.byte_lane_enable_n <= wr_go_reg ? ~wbe_hi_go_reg : '1;
      wr_go_reg <= 1'b0;
    end
  end

  // Read capture on echo clock edges
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rsync1_reg <= '0;
      rsync2_reg <= '0;
      cq_prev_reg <= 1'b0;
      cqn_prev_reg <= 1'b0;
      beat_idx_reg <= 1'b0;
      lo_reg <= '0;
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rsync1_reg <= {bus.echo_timing_strobe, bus.echo_timing_strobe_n, bus.rdata_oe, bus.rdata};
      rsync2_reg <= rsync1_reg;
      cq_prev_reg <= cq_s;
      cqn_prev_reg <= cqn_s;
      rd_valid <= 1'b0;
      if (!oe_s) begin
        beat_idx_reg <= 1'b0;
      end else if ((cq_s & ~cq_prev_reg) | (cqn_s & ~cqn_prev_reg)) begin
        beat_idx_reg <= ~beat_idx_reg;
        if (!beat_idx_reg) begin
          lo_reg <= q_s;
        end else begin
          rd_data <= {q_s, lo_reg};
          rd_valid <= 1'b1;
        end
      end
    end
  end
endmodule : dpbs_ctrl
`default_nettype wire

// *** dv/dpbs_properties.sv ***
// Assertions on the pins between the burst SRAM controller and device
`timescale 1ns/1ps
`default_nettype none
module dpbs_properties (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Asynchronous reset
  input wire logic input_strobe_true, // Input clock
  input wire logic output_timing_true, // Output clock
  input wire logic output_timing_comp, // Output clock complement
  input wire logic read_port_select_n, // Read select
  input wire logic write_port_select_n, // Write select
  input wire logic pll_bypass_n, // PLL strap
  input wire logic rdata_oe, // Read data driven
  input wire logic echo_timing_strobe, // Echo strobe
  input wire logic echo_timing_strobe_n // Echo strobe complement
);
  logic k_q;
  logic [6:0] up_cnt;
  logic [6:0] rd_age;
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n) k_q <= 1'b1;
    else k_q <= input_strobe_true;
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n) up_cnt <= 7'h0;
    else if (up_cnt != 7'h7f) up_cnt <= up_cnt + 7'h1;
  // Cycles since the last input clock rise that carried a read select
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n) rd_age <= 7'h7f;
    else if (input_strobe_true && !k_q && !read_port_select_n) rd_age <= 7'h0;
    else if (rd_age != 7'h7f) rd_age <= rd_age + 7'h1;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  sequence s_read_start;
    input_strobe_true && !k_q && !read_port_select_n;
  endsequence
  sequence s_burst;
    $rose(rdata_oe);
  endsequence
  a_sel_k_low: assert property (input_strobe_true && !k_q
    |-> $stable(read_port_select_n) && $stable(write_port_select_n))
    else $error("select moved at input clock rise");
  a_power_idle: assert property (up_cnt < 7'h3
    |-> !rdata_oe && read_port_select_n && write_port_select_n) else $error("not idle");
  a_oe_after_read: assert property (rdata_oe |-> rd_age < 7'h28)
    else $error("read data driven with no read");
  a_legacy_lat: assert property (s_burst ##0 !pll_bypass_n
    |-> rd_age >= 7'h08 && rd_age <= 7'h10) else $error("legacy latency wrong");
  a_pll_lat: assert property (s_burst ##0 pll_bypass_n
    |-> rd_age >= 7'h0c && rd_age <= 7'h14) else $error("pll latency wrong");
  a_strap_hold: assert property (up_cnt > 7'h4 |-> $stable(pll_bypass_n))
    else $error("pll strap changed");
  a_single_hold: assert property ((up_cnt == 7'h7f) && $past(output_timing_true)
    && $past(output_timing_comp) |-> output_timing_true && output_timing_comp)
    else $error("single clock strap left");
  a_echo_out: assert property ((up_cnt > 7'h8)
    && ($past(output_timing_true, 4) != $past(output_timing_comp, 4))
    |-> echo_timing_strobe == $past(output_timing_true, 4)
    && echo_timing_strobe_n == $past(output_timing_comp, 4)) else $error("echo wrong");
  a_echo_single: assert property ((up_cnt > 7'h40) && $past(output_timing_true, 4)
    && $past(output_timing_comp, 4) |-> echo_timing_strobe == $past(input_strobe_true, 4))
    else $error("single mode echo wrong");
  c_read: cover property (s_read_start);
endmodule : dpbs_properties
`default_nettype wire

// *** dv/dual_port_burst_sram_tb_top.sv ***
// Self-checking bench for the burst SRAM controller and device pair
`timescale 1ns/1ps
`default_nettype none
module dual_port_burst_sram_tb_top;
  import dpbs_pkg::*;
  localparam int LOCK = 20;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic use_pll = 1'b0;
  logic single_clock = 1'b0;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic [DPBS_ADDR_W-1:0] rd_addr = 21'h0;
  logic [DPBS_ADDR_W-1:0] wr_addr = 21'h0;
  logic [DPBS_ROW_W-1:0] wr_data = 36'h0;
  logic [3:0] wr_be = 4'h0;
  logic rd_ready;
  logic rd_valid;
  logic wr_ready;
  logic pll_locked;
  logic impedance_tune;
  logic single_clock_mode;
  logic [DPBS_ROW_W-1:0] rd_data;
  logic [DPBS_ROW_W-1:0] mem [8];
  logic [3:0] lanes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  int mismatches = 0;
  int checks_done = 0;
  always #12.5 clk_sys = ~clk_sys;
  dpbs_if u_dpbs_if ();
  dpbs_ctrl #(.LOCK_CYC(LOCK)) u_dpbs_ctrl (
    .clk_sys(clk_sys), .reset_n(reset_n), .bus(u_dpbs_if), .use_pll(use_pll),
    .single_clock(single_clock), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .wr_req(wr_req), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_be(wr_be), .wr_ready(wr_ready)
  );
  dpbs_device #(.MEM_AW(8), .LOCK_CYC(LOCK)) u_dpbs_device (
    .clk_sys(clk_sys), .reset_n(reset_n), .bus(u_dpbs_if), .pll_locked(pll_locked),
    .impedance_tune(impedance_tune), .single_clock_mode(single_clock_mode)
  );
  dpbs_properties u_dpbs_properties (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .input_strobe_true(u_dpbs_if.input_strobe_true),
    .output_timing_true(u_dpbs_if.output_timing_true),
    .output_timing_comp(u_dpbs_if.output_timing_comp),
    .read_port_select_n(u_dpbs_if.read_port_select_n),
    .write_port_select_n(u_dpbs_if.write_port_select_n),
    .pll_bypass_n(u_dpbs_if.pll_bypass_n), .rdata_oe(u_dpbs_if.rdata_oe),
    .echo_timing_strobe(u_dpbs_if.echo_timing_strobe),
    .echo_timing_strobe_n(u_dpbs_if.echo_timing_strobe_n)
  );
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                        input logic [3:0] be);
    merge = o;
    for (int i = 0; i < 4; i++) if (be[i]) merge[9*i+:9] = n[9*i+:9];
  endfunction : merge
  function automatic logic [35:0] rnd();
    rnd = {4'($urandom), $urandom};
  endfunction : rnd
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step
  task automatic wait_on(ref logic s, input int lim);
    int n;
    n = 0;
    step();
    while (s !== 1'b1) begin
      n++;
      if (n > lim) begin
        mismatches++;
        conclude();
      end
      step();
    end
  endtask : wait_on
  // One write, one read or both issued at the same clock edge
  task automatic xfer(input bit dw, input bit dr, input logic [2:0] wi, input logic [35:0] d,
                      input logic [3:0] be, input logic [2:0] ri);
    if (dw) wait_on(wr_ready, 2000);
    if (dr) wait_on(rd_ready, 2000);
    @(posedge clk_sys);
    wr_req <= dw;
    rd_req <= dr;
    wr_addr <= {13'h0, wi, 5'h0b};
    rd_addr <= {13'h0, ri, 5'h0b};
    wr_data <= d;
    wr_be <= be;
    @(posedge clk_sys);
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    if (dw) mem[wi] = merge(mem[wi], d, be);
    if (dr) begin
      wait_on(rd_valid, 200);
      check(rd_data, mem[ri]);
    end
  endtask : xfer
  task automatic run_mode(input logic p, input logic s);
    logic [1:0] op;
    time t0;
    @(posedge clk_sys);
    reset_n <= 1'b0;
    use_pll <= p;
    single_clock <= s;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    t0 = $time;
    step();
    check(pll_locked, 1'b0);
    if (p) begin
      wait_on(pll_locked, 2000);
      check(($time - t0) >= LOCK * DPBS_CLK_NS, 1'b1);
    end
    wait_on(wr_ready, 2000);
    check(pll_locked, p);
    for (int i = 0; i < 8; i++) xfer(1'b1, 1'b0, 3'(i), rnd(), 4'hf, 3'h0);
    check(single_clock_mode, s);
    for (int i = 0; i < 8; i++) xfer(1'b0, 1'b1, 3'h0, 36'h0, 4'h0, 3'(i));
    for (int l = 0; l < 5; l++) begin
      xfer(1'b1, 1'b0, 3'h1, rnd(), lanes[l], 3'h0);
      xfer(1'b0, 1'b1, 3'h0, 36'h0, 4'h0, 3'h1);
    end
    xfer(1'b1, 1'b0, 3'h2, rnd(), 4'hf, 3'h0);
    xfer(1'b0, 1'b1, 3'h0, 36'h0, 4'h0, 3'h2);
    xfer(1'b1, 1'b1, 3'h3, rnd(), 4'h5, 3'h4);
    xfer(1'b1, 1'b1, 3'h5, rnd(), 4'ha, 3'h5);
    for (int k = 0; k < 12; k++) begin
      op = 2'($urandom_range(1, 3));
      xfer(op[0], op[1], 3'($urandom), rnd(), 4'($urandom), 3'($urandom));
    end
    $display("mode pll %0d single %0d done", p, s);
  endtask : run_mode
  initial begin
    time t0;
    void'($urandom(32'h2a64e8df));
    run_mode(1'b0, 1'b0);
    wait_on(impedance_tune, 9000);
    t0 = $time;
    wait_on(impedance_tune, 9000);
    check(($time - t0) == 2 * DPBS_K_HALF * DPBS_ZQ_PERIOD * DPBS_CLK_NS, 1'b1);
    $display("impedance retune test done");
    run_mode(1'b1, 1'b0);
    run_mode(1'b1, 1'b1);
    conclude();
  end
endmodule : dual_port_burst_sram_tb_top
`default_nettype wire
